// ==== verilog/srcl_loader.sv ====
// Purpose: load default configuration from a serial rom, then serve host access
// Assumes: rom link logic runs on romClk; the rom drives romDo only on read/busy
// Notes:   requests cross to the link domain by a toggle with held data
//
// Function
// - drive 256 or 512 byte serial rom
// - load defaults after every reset
// - hold off usb until load finishes
// - six address bytes become station address
// - no valid rom, no station address
// - byte 0 signature, bytes 1-6 address
// - polling intervals, flags, language id layout
// - five string length/offset pairs follow
// - four descriptor length/offset pairs follow
// - wake enable bits and pme flag byte
// - descriptor offsets count 16-bit words
// - zero length means use hardware default
// - no strings means no language id
// - force descriptor types and size
// - bytes above 20h are ignored
// - flags beat strap, descriptor beats both
// - flag bit 2 enables remote wakeup
// - flag bit 0 selects self power
// - flag bit 1 seeds led function select
// - host may read, write, erase rom

`timescale 1ns/1ps

module srcl_loader import srcl_pkg::*; #(
  parameter int   AW             = ROM_AW,
  parameter int   PROG_WAIT      = PROG_WAIT_CYC,
  parameter int   SK_HALF        = SK_HALF_CYC,
  parameter logic SELF_POWER_DEF = 1'b0,
  parameter logic LED_FUNCTION_SELECT_DEF    = 1'b0
) (
  // core clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // rom link
  input  wire logic              romClk,
  output logic                   romCs,
  output logic                   romSk,
  output logic                   romDi,
  input  wire logic              romDo,
  // straps and descriptor overrides
  input  wire logic              remoteWakeStrap,
  input  wire logic              cfgDescWake,
  input  wire logic              cfgDescSelfPower,
  // host rom access
  input  wire logic              hostReq,
  input  wire srcl_op_t          hostOp,
  input  wire logic [AW-1:0]     hostAddr,
  input  wire logic [7:0]        hostWdata,
  output logic                   hostBusy,
  output logic                   hostDone,
  output logic [7:0]             hostRdata,
  // load status
  output logic                   usbHold,
  output logic                   romValid,
  // station address
  output logic [15:0]            stationAddrHigh,
  output logic [31:0]            stationAddrLow,
  output logic                   stationAddrValid,
  // loaded settings
  output logic [7:0]             fsPollInterval,
  output logic [7:0]             hsPollInterval,
  output logic                   selfPowered,
  output logic                   ledFunctionSelect,
  output logic                   remoteWakeEnable,
  output logic [15:0]            langId,
  output logic                   langIdSupported,
  output logic [WAKE_BITS-1:0]   pinWakeEnableBits,
  output logic [7:0]             pmeFlags,
  // forced descriptor fields
  output logic [7:0]             devDescType,
  output logic [7:0]             devDescSize,
  output logic [7:0]             cfgDescType,
  // descriptor lookup
  input  wire logic [DSEL_W-1:0] descSel,
  output logic [7:0]             descLen,
  output logic [8:0]             descByteAddr,
  output logic                   descPresent
);
  // ************************************************************
  // core domain declarations
  // ************************************************************
  typedef enum logic [1:0] {C_BOOT, C_BOOTWAIT, C_READY, C_HOSTWAIT} srcl_core_t;
  srcl_core_t             state_q;
  logic [CFG_AW-1:0]      ldAddr_q;
  logic                   loaded_q;
  logic                   reqTgl_q;
  srcl_op_t               reqOp_q;
  logic [AW-1:0]          reqAddr_q;
  logic [7:0]             reqData_q;
  logic                   ackSync;
  logic                   ackSeen_q;
  logic                   strapSync;
  logic [47:0]            mac_q;
  logic [7:0]             flags_q;
  logic [8:0]             pairPresent_q;
  logic                   selOk_q;
  logic [15:0]            pairData;

  // ************************************************************
  // link domain declarations
  // ************************************************************
  localparam int FL = 3 + AW + 8;
  localparam int CW = $clog2(FL + 1);
  localparam int WW = $clog2(PROG_WAIT + 1);
  localparam int HW = $clog2(SK_HALF + 1);
  typedef enum logic [2:0] {E_IDLE, E_SHIFT, E_READ, E_GAP, E_POLL, E_END} srcl_eng_t;
  srcl_eng_t              eng_q;
  logic                   reqSync;
  logic                   doSync;
  logic                   reqSeen_q;
  logic                   ackTgl_q;
  logic [7:0]             rdData_q;
  logic [FL-1:0]          frame_q;
  logic [CW-1:0]          bits_q;
  logic [HW-1:0]          div_q;
  logic [WW-1:0]          wait_q;
  logic [3:0]             rdCnt_q;

  // ************************************************************
  // crossings
  // ************************************************************
  srcl_sync #(.W(1)) uAckSync (
    .clk  (ref_clk),
    .nrst (nrst),
    .din  (ackTgl_q),
    .dout (ackSync)
  );
  srcl_sync #(.W(1)) uStrapSync (
    .clk  (ref_clk),
    .nrst (nrst),
    .din  (remoteWakeStrap),
    .dout (strapSync)
  );
  srcl_sync #(.W(1)) uReqSync (
    .clk  (romClk),
    .nrst (nrst),
    .din  (reqTgl_q),
    .dout (reqSync)
  );
  srcl_sync #(.W(1)) uDoSync (
    .clk  (romClk),
    .nrst (nrst),
    .din  (romDo),
    .dout (doSync)
  );

  // ************************************************************
  // core decode
  // ************************************************************
  wire             ackPulse   = ackSync != ackSeen_q;
  wire             loadAck    = (state_q == C_BOOTWAIT) && ackPulse;
  wire             sigBad     = (ldAddr_q == B_SIG) && (rdData_q != ROM_SIGNATURE);
  wire             loadLast   = ldAddr_q == CFG_LAST;
  wire             storeByte  = loadAck && !sigBad;
  wire             bootEnd    = loadAck && (sigBad || loadLast);
  wire             hostAccept = (state_q == C_READY) && hostReq;
  wire             hostAck    = (state_q == C_HOSTWAIT) && ackPulse;
  wire             issue      = (state_q == C_BOOT) || hostAccept;
  wire [CFG_AW-1:0] macIdx    = ldAddr_q - B_MAC0;
  wire             isMac      = (ldAddr_q >= B_MAC0) && (ldAddr_q <= B_MAC5);
  wire [CFG_AW-1:0] pairOff   = ldAddr_q - B_PAIR_BASE;
  wire             isPairLen  = (ldAddr_q >= B_PAIR_BASE) && (ldAddr_q <= B_PAIR_LAST)
                                && !pairOff[0];
  wire [3:0]       pairIdx    = pairOff[4:1];
  wire             cfgDescIn  = pairPresent_q[P_HS_CFG] | pairPresent_q[P_FS_CFG];
  wire [CFG_AW-1:0] memRaddr  = B_PAIR_BASE + CFG_AW'({descSel, 1'b0});
  wire             selValid   = loaded_q && selOk_q;

  // ************************************************************
  // core sequencer: boot load, then host service
  // ************************************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= C_BOOT;
    end else begin
      case (state_q)
        C_BOOT:     state_q <= C_BOOTWAIT;
        C_BOOTWAIT: if (ackPulse) state_q <= (sigBad || loadLast) ? C_READY : C_BOOT;
        C_READY:    if (hostReq) state_q <= C_HOSTWAIT;
        C_HOSTWAIT: if (ackPulse) state_q <= C_READY;
        default:    state_q <= C_BOOT;
      endcase
    end
  end

  // load pointer walks 00h..20h, never beyond
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ldAddr_q <= B_SIG;
      loaded_q <= 1'b0;
    end else begin
      if (storeByte && !loadLast) ldAddr_q <= ldAddr_q + CFG_AW'(1);
      if (storeByte && loadLast) loaded_q <= 1'b1;
    end
  end

  // request to link: data held steady until the toggle is answered
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reqTgl_q  <= 1'b0;
      reqOp_q   <= OP_READ;
      reqAddr_q <= '0;
      reqData_q <= '0;
      ackSeen_q <= 1'b0;
    end else begin
      ackSeen_q <= ackSync;
      if (issue) begin
        reqTgl_q  <= ~reqTgl_q;
        reqOp_q   <= (state_q == C_BOOT) ? OP_READ : hostOp;
        reqAddr_q <= (state_q == C_BOOT) ? AW'(ldAddr_q) : hostAddr;
        reqData_q <= hostWdata;
      end
    end
  end

  // usb hold and host handshake; hold lifts only once the boot sequence ends
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      usbHold   <= 1'b1;
      hostBusy  <= 1'b1;
      hostDone  <= 1'b0;
      hostRdata <= '0;
      romValid  <= 1'b0;
    end else begin
      hostDone <= hostAck;
      if (bootEnd) usbHold <= 1'b0;
      if (bootEnd || hostAck) hostBusy <= 1'b0;
      else if (hostAccept) hostBusy <= 1'b1;
      if (hostAck) hostRdata <= rdData_q;
      if (storeByte && (ldAddr_q == B_SIG)) romValid <= 1'b1;
    end
  end

  // ************************************************************
  // captured image fields
  // ************************************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mac_q             <= '0;
      fsPollInterval    <= '0;
      hsPollInterval    <= '0;
      flags_q           <= '0;
      langId            <= '0;
      pinWakeEnableBits <= '0;
      pmeFlags          <= '0;
      pairPresent_q     <= '0;
    end else if (storeByte) begin
      if (isMac) mac_q[8*macIdx +: 8] <= rdData_q;
      if (ldAddr_q == B_FS_POLL) fsPollInterval <= rdData_q;
      if (ldAddr_q == B_HS_POLL) hsPollInterval <= rdData_q;
      if (ldAddr_q == B_FLAGS) flags_q <= rdData_q;
      if (ldAddr_q == B_LANG_LO) langId[7:0] <= rdData_q;
      if (ldAddr_q == B_LANG_HI) langId[15:8] <= rdData_q;
      if (ldAddr_q == B_WAKE_LO) pinWakeEnableBits[7:0] <= rdData_q;
      if (ldAddr_q == B_WAKE_HI) begin
        pinWakeEnableBits[WAKE_BITS-1:8] <= rdData_q[WAKE_BITS-9:0];
      end
      if (ldAddr_q == CFG_LAST) pmeFlags <= rdData_q;
      if (isPairLen) pairPresent_q[pairIdx] <= rdData_q != 8'h00;
    end
  end

  // station address only goes valid after a complete signed load
  assign stationAddrHigh = mac_q[47:32];
  assign stationAddrLow  = mac_q[31:0];
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) stationAddrValid <= 1'b0;
    else       stationAddrValid <= loaded_q;
  end

  // ************************************************************
  // derived settings with precedence
  // ************************************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      selfPowered       <= SELF_POWER_DEF;
      ledFunctionSelect <= LED_FUNCTION_SELECT_DEF;
      remoteWakeEnable  <= 1'b0;
      langIdSupported   <= 1'b0;
    end else begin
      if (loaded_q && cfgDescIn) remoteWakeEnable <= cfgDescWake;
      else if (loaded_q) remoteWakeEnable <= flags_q[FLAG_WAKE];
      else remoteWakeEnable <= strapSync;
      if (loaded_q && cfgDescIn) selfPowered <= cfgDescSelfPower;
      else if (loaded_q) selfPowered <= flags_q[FLAG_SELF_PWR];
      else selfPowered <= SELF_POWER_DEF;
      ledFunctionSelect <= loaded_q ? flags_q[FLAG_LED_FUNCTION_SELECT] : LED_FUNCTION_SELECT_DEF;
      langIdSupported <= loaded_q && (|pairPresent_q[STR_COUNT-1:0]);
    end
  end

  // forced descriptor fields never follow the image
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      devDescType <= DEV_DESC_TYPE;
      devDescSize <= DEV_DESC_SIZE;
      cfgDescType <= CFG_DESC_TYPE;
    end else begin
      devDescType <= DEV_DESC_TYPE;
      devDescSize <= DEV_DESC_SIZE;
      cfgDescType <= CFG_DESC_TYPE;
    end
  end

  // ************************************************************
  // descriptor lookup: two cycles from select to answer
  // ************************************************************
  srcl_cfg_mem #(.DEPTH(CFG_BYTES), .AW(CFG_AW)) uImage (
    .clk   (ref_clk),
    .nrst  (nrst),
    .we    (storeByte),
    .waddr (ldAddr_q),
    .wdata (rdData_q),
    .raddr (memRaddr),
    .rdata (pairData)
  );

  // unloaded or out-of-range selects answer absent, length zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      selOk_q      <= 1'b0;
      descLen      <= '0;
      descByteAddr <= '0;
      descPresent  <= 1'b0;
    end else begin
      selOk_q      <= descSel < PAIR_COUNT;
      descLen      <= selValid ? pairData[7:0] : 8'h00;
      descByteAddr <= selValid ? {pairData[15:8], 1'b0} : 9'h000;
      descPresent  <= selValid && (pairData[7:0] != 8'h00);
    end
  end

  // ************************************************************
  // link engine on romClk
  // ************************************************************
  wire            start     = (eng_q == E_IDLE) && (reqSync != reqSeen_q);
  wire            phaseEnd  = div_q == HW'(SK_HALF - 1);
  wire            riseNext  = phaseEnd && !romSk;
  wire            fallNext  = phaseEnd && romSk;
  wire [AW-1:0]   addrField = (reqOp_q == OP_EWEN) ? {EWEN_PFX, {(AW-2){1'b0}}} : reqAddr_q;
  wire [FL-1:0]   frameNew  = {1'b1, reqOp_q, addrField, reqData_q};
  wire [CW-1:0]   frameLen  = (reqOp_q == OP_WRITE) ? CW'(FL) : CW'(FL - 8);
  wire            lastBit   = fallNext && (bits_q == CW'(1));
  wire            rdLast    = riseNext && (rdCnt_q == 4'h8);
  // busy stays ignored for one half period so stale data-out is not taken as ready
  wire            waitDone  = (doSync && (wait_q > WW'(SK_HALF))) ||
                              (wait_q == WW'(PROG_WAIT - 1));

  // serial clock divider runs only inside a frame
  always_ff @(posedge romClk or negedge nrst) begin
    if (!nrst)                div_q <= '0;
    else if (eng_q == E_IDLE) div_q <= '0;
    else                      div_q <= phaseEnd ? '0 : div_q + HW'(1);
  end

  // frame sequencer: start bit, opcode, address, optional data, then read or busy poll
  always_ff @(posedge romClk or negedge nrst) begin
    if (!nrst) begin
      eng_q     <= E_IDLE;
      romCs     <= 1'b0;
      romSk     <= 1'b0;
      romDi     <= 1'b0;
      reqSeen_q <= 1'b0;
      ackTgl_q  <= 1'b0;
      frame_q   <= '0;
      bits_q    <= '0;
      rdCnt_q   <= '0;
      wait_q    <= '0;
      rdData_q  <= '0;
    end else begin
      case (eng_q)
        E_IDLE: if (start) begin
          reqSeen_q <= reqSync;
          frame_q   <= frameNew;
          bits_q    <= frameLen;
          romCs     <= 1'b1;
          romDi     <= frameNew[FL-1];
          eng_q     <= E_SHIFT;
        end
        E_SHIFT: begin
          if (phaseEnd) romSk <= ~romSk;
          if (fallNext) begin
            frame_q <= frame_q << 1;
            romDi   <= frame_q[FL-2];
            bits_q  <= bits_q - CW'(1);
          end
          if (lastBit) begin
            romDi   <= 1'b0;
            rdCnt_q <= '0;
            case (reqOp_q)
              OP_READ:  eng_q <= E_READ;
              OP_EWEN:  eng_q <= E_END;
              default:  eng_q <= E_GAP;
            endcase
          end
        end
        E_READ: begin
          if (phaseEnd && !rdLast) romSk <= ~romSk;
          if (riseNext) begin
            rdData_q <= {rdData_q[6:0], doSync};      // dummy bit shifts out
            rdCnt_q  <= rdCnt_q + 4'h1;
          end
          if (rdLast) eng_q <= E_END;
        end
        E_GAP: begin
          romCs <= 1'b0;
          if (phaseEnd) begin
            romCs  <= 1'b1;
            wait_q <= '0;
            eng_q  <= E_POLL;
          end
        end
        E_POLL: begin
          wait_q <= wait_q + WW'(1);
          if (waitDone) eng_q <= E_END;
        end
        E_END: begin
          romCs    <= 1'b0;
          romSk    <= 1'b0;
          ackTgl_q <= ~ackTgl_q;
          eng_q    <= E_IDLE;
        end
        default: eng_q <= E_IDLE;
      endcase
    end
  end
endmodule : srcl_loader

// ==== verilog/srcl_pkg.sv ====
// Purpose: shared constants for the serial rom configuration loader
// Assumes: byte-organised three-wire serial rom, 9 address bits by default
// Notes:   byte map of the stored configuration image lives here

package srcl_pkg;
  // ************************************************************
  // rom geometry and image layout
  // ************************************************************
  localparam int             ROM_AW        = 9;
  localparam int             CFG_BYTES     = 33;
  localparam int             CFG_AW        = 6;
  localparam logic [7:0]     ROM_SIGNATURE = 8'hA5;
  localparam logic [5:0]     B_SIG         = 6'h00;
  localparam logic [5:0]     B_MAC0        = 6'h01;
  localparam logic [5:0]     B_MAC5        = 6'h06;
  localparam logic [5:0]     B_FS_POLL     = 6'h07;
  localparam logic [5:0]     B_HS_POLL     = 6'h08;
  localparam logic [5:0]     B_FLAGS       = 6'h09;
  localparam logic [5:0]     B_LANG_LO     = 6'h0A;
  localparam logic [5:0]     B_LANG_HI     = 6'h0B;
  localparam logic [5:0]     B_PAIR_BASE   = 6'h0C;
  localparam logic [5:0]     B_PAIR_LAST   = 6'h1D;
  localparam logic [5:0]     B_WAKE_LO     = 6'h1E;
  localparam logic [5:0]     B_WAKE_HI     = 6'h1F;
  localparam logic [5:0]     CFG_LAST      = 6'h20;

  // ************************************************************
  // descriptor pairs, flag bits, forced descriptor fields
  // ************************************************************
  localparam int             DSEL_W        = 4;
  localparam logic [3:0]     PAIR_COUNT    = 4'h9;
  localparam int             STR_COUNT     = 5;
  localparam int             P_HS_CFG      = 6;
  localparam int             P_FS_CFG      = 8;
  localparam int             FLAG_SELF_PWR = 0;
  localparam int             FLAG_LED_FUNCTION_SELECT  = 1;
  localparam int             FLAG_WAKE     = 2;
  localparam int             WAKE_BITS     = 11;
  localparam logic [7:0]     DEV_DESC_TYPE = 8'h01;
  localparam logic [7:0]     DEV_DESC_SIZE = 8'h12;
  localparam logic [7:0]     CFG_DESC_TYPE = 8'h02;

  // ************************************************************
  // serial command codes and link timing
  // ************************************************************
  typedef enum logic [1:0] {
    OP_EWEN  = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ  = 2'h2,
    OP_ERASE = 2'h3
  } srcl_op_t;
  localparam logic [1:0]     EWEN_PFX      = 2'h3;
  localparam int             LINK_PERIOD_NS = 160;
  localparam int             PROG_TIME_NS  = 10000000;
  localparam int             PROG_WAIT_CYC =
    (PROG_TIME_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int             SK_HALF_CYC   = 4;
endpackage : srcl_pkg

// ==== verilog/srcl_sync.sv ====
// Purpose: three-stage synchroniser for a level from another clock domain
// Assumes: input changes slower than three destination clocks
// Notes:   output follows only once stages two and three agree

`timescale 1ns/1ps

module srcl_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // level in and filtered level out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // stage one feeds stage two only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      dout <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) dout <= s3_q;
    end
  end
endmodule : srcl_sync

// ==== verilog/srcl_cfg_mem.sv ====
// Purpose: small store for the loaded configuration image
// Assumes: read address plus one stays inside the store
// Notes:   reads return a byte pair, low byte at the given address

`timescale 1ns/1ps

module srcl_cfg_mem #(
  parameter int DEPTH = 33,
  parameter int AW    = 6
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  // read port
  input  wire logic [AW-1:0] raddr,
  output logic      [15:0]   rdata
);
  logic [7:0] mem [0:DEPTH-1];
  wire  [AW-1:0] raddrHi = raddr + AW'(1);

  // storage has no reset; contents are only trusted after a load
  always_ff @(posedge clk) begin
    if (we) mem[waddr] <= wdata;
  end

  // registered read of a length/offset pair
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rdata <= '0;
    else       rdata <= {mem[raddrHi], mem[raddr]};
  end
endmodule : srcl_cfg_mem

// ==== verif/srcl_rom_model.sv ====
// Purpose: behavioural byte-wide three-wire serial rom
// Assumes: 9 address bits, one dummy zero before read data
// Notes:   released data line shows the inverse of its last value
`timescale 1ns/1ps
module srcl_rom_model (
  // link pins
  input  wire logic romClk,
  input  wire logic romCs,
  input  wire logic romSk,
  input  wire logic romDi,
  output logic      romDo
);
  logic [7:0]  mem [512];
  logic [20:0] sh;
  logic [8:0]  a;
  logic [1:0]  op;
  logic        csq, skq, en, pd, pl;
  int          n, bz;
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'hFF;
    {romDo, csq, skq, en, pd, pl, n, bz} = '0;
  end
  // edges of select and clock seen on the link clock; busy lasts 20 cycles
  always @(posedge romClk) begin
    csq <= romCs;
    skq <= romSk;
    if (bz > 0) bz = bz - 1;
    if (!romCs && csq) begin
      n = 0;
      pl = pd;
      pd = 1'b0;
      bz = 20;
      romDo <= ~romDo;
    end else if (romCs && romSk && !skq) begin
      sh = {sh[19:0], romDi};
      n = n + 1;
      if (n == 12) {op, a} = sh[10:0];
      if (n == 12 && op == 2'h0 && a[8:7] == 2'h3) en = 1'b1;
      if (n == 12 && op == 2'h3 && en) {mem[a], pd} = {8'hFF, 1'b1};
      if (n == 20 && op == 2'h1 && en) {mem[a], pd} = {sh[7:0], 1'b1};
      if (n >= 12 && n <= 20 && op == 2'h2) romDo <= (n == 12) ? 1'b0 : mem[a][20-n];
    end else if (pl && romCs) romDo <= (bz == 0);
  end
endmodule : srcl_rom_model

// ==== verif/srcl_loader_checker.sv ====
// Purpose: port assertions for the configuration loader
// Assumes: bound into srcl_loader
// Notes:   link framing is checked on the link clock
`timescale 1ns/1ps
module srcl_loader_checker (
  // clocks and reset
  input wire logic        ref_clk,
  input wire logic        romClk,
  input wire logic        nrst,
  // watched outputs
  input wire logic        romCs,
  input wire logic        romSk,
  input wire logic        usbHold,
  input wire logic        romValid,
  input wire logic        hostBusy,
  input wire logic        hostDone,
  input wire logic [7:0]  hostRdata,
  input wire logic        stationAddrValid,
  input wire logic [31:0] stationAddrLow,
  input wire logic [7:0]  devDescType,
  input wire logic [7:0]  devDescSize,
  input wire logic [7:0]  cfgDescType,
  input wire logic        descPresent,
  input wire logic [7:0]  descLen
);
  chk_desc_fixed: assert property (@(posedge ref_clk) disable iff (!nrst)
    devDescType == 8'h01 && devDescSize == 8'h12 && cfgDescType == 8'h02) else $error("fixed");
  chk_usb_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    stationAddrValid |-> !usbHold) else $error("usb hold");
  chk_sig_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
    stationAddrValid |-> romValid) else $error("signature gate");
  chk_no_addr: assert property (@(posedge ref_clk) disable iff (!nrst)
    !romValid |-> stationAddrLow == 32'h0) else $error("addr without rom");
  chk_done_once: assert property (@(posedge ref_clk) disable iff (!nrst)
    hostDone |=> !hostDone) else $error("done width");
  chk_busy_end: assert property (@(posedge ref_clk) disable iff (!nrst)
    hostDone |-> !hostBusy && $past(hostBusy)) else $error("busy end");
  chk_rdata_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    !$stable(hostRdata) |-> hostDone) else $error("rdata moved");
  chk_desc_valid: assert property (@(posedge ref_clk) disable iff (!nrst)
    descPresent |-> descLen != 8'h00 && romValid) else $error("desc present");
  chk_cs_idle: assert property (@(posedge romClk) disable iff (!nrst)
    !romCs |-> !romSk) else $error("clock outside frame");
endmodule : srcl_loader_checker

// ==== verif/srcl_loader_test.sv ====
// Purpose: boot, lookup and host access tests of the loader
// Assumes: program wait shortened to 40 link cycles
// Notes:   boot of a signed image dominates run time
`timescale 1ns/1ps
module srcl_loader_test import srcl_pkg::*; ;
  logic ref_clk = 0, romClk = 0, nrst = 0, hostReq = 0, remoteWakeStrap = 1;
  logic cfgDescWake = 0, cfgDescSelfPower = 0, romCs, romSk, romDi, romDo, hostBusy, hostDone;
  logic usbHold, romValid, stationAddrValid, selfPowered, ledFunctionSelect, remoteWakeEnable;
  logic langIdSupported, descPresent;
  srcl_op_t hostOp = OP_READ;
  logic [8:0] hostAddr = 9'h000, descByteAddr;
  logic [7:0] hostWdata = 8'h00, hostRdata, fsPollInterval, hsPollInterval, pmeFlags, descLen;
  logic [7:0] devDescType, devDescSize, cfgDescType, e;
  logic [7:0] img [33];
  logic [3:0] descSel = 4'h0;
  logic [15:0] stationAddrHigh, langId;
  logic [31:0] stationAddrLow;
  logic [10:0] pinWakeEnableBits;
  int err_count = 0, checks_done = 0;
  srcl_loader #(.PROG_WAIT(40)) srcl_loader_inst (.*);
  srcl_rom_model srcl_rom_model_inst (.*);
  // core clock 4 ns; link clock 160 ns with an odd phase
  always #2 ref_clk = ~ref_clk;
  initial #37 forever #80 romClk = ~romClk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  // bounded wait on done (w=1) or busy (w=0)
  task automatic await(input bit w, input logic v);
    for (int k = 0; (w ? hostDone : hostBusy) !== v; k++) begin
      @(posedge ref_clk);
      if (k > 400000) begin
        err_count++;
        final_report();
      end
    end
  endtask : await
  task automatic cmd(input srcl_op_t op, input logic [8:0] a, input logic [7:0] d);
    hostReq <= 1'b1;
    hostOp <= op;
    hostAddr <= a;
    hostWdata <= d;
    @(posedge ref_clk);
    hostReq <= 1'b0;
    await(1'b1, 1'b1);
  endtask : cmd
  // image: string 0 absent, both config descriptors absent, device ones 18 bytes
  initial begin
    for (int i = 0; i < 33; i++) img[i] = 8'h30 + 8'(i);
    {img[9], img[12], img[22], img[24], img[26], img[28]} =
      {8'h03, 8'h00, 8'h12, 8'h00, 8'h12, 8'h00};
    repeat (3) @(posedge ref_clk);
    for (int i = 1; i < 33; i++) srcl_rom_model_inst.mem[i] = img[i];
    srcl_rom_model_inst.mem[0] = 8'h5A;
    nrst <= 1'b1;
    await(1'b0, 1'b0);
    chk("noLoad", {romValid, usbHold, stationAddrValid, remoteWakeEnable}, 4'h1);
    chk("addrLow", stationAddrLow, 32'h0);
    $display("test bad signature done");
    srcl_rom_model_inst.mem[0] = 8'hA5;
    nrst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    await(1'b0, 1'b0);
    repeat (2) @(posedge ref_clk);
    chk("status", {stationAddrValid, usbHold, romValid}, 3'h5);
    chk("addrLow", stationAddrLow, 32'h34333231);
    chk("addrHigh", stationAddrHigh, 16'h3635);
    chk("polls", {fsPollInterval, hsPollInterval, langId}, 32'h37383B3A);
    chk("wake", {pinWakeEnableBits, pmeFlags}, 19'h74E50);
    chk("flags", {selfPowered, ledFunctionSelect, remoteWakeEnable, langIdSupported},
      4'hD);
    for (int s = 0; s < 10; s++) begin
      descSel <= 4'(s);
      repeat (3) @(posedge ref_clk);
      e = (s < 9) ? img[12+2*s] : 8'h00;
      chk("descLen", {descLen, descPresent}, {e, e != 8'h00});
      if (e != 8'h00) chk("descAddr", descByteAddr, {img[13+2*s], 1'b0});
    end
    $display("test boot load done");
    cmd(OP_READ, 9'h005, 8'h00);
    chk("rd", hostRdata, img[5]);
    cmd(OP_EWEN, 9'h000, 8'h00);
    cmd(OP_WRITE, 9'h1FF, 8'h3C);
    cmd(OP_READ, 9'h1FF, 8'h00);
    chk("rdWrite", hostRdata, 8'h3C);
    cmd(OP_ERASE, 9'h1FF, 8'h00);
    cmd(OP_READ, 9'h1FF, 8'h00);
    chk("rdErase", hostRdata, 8'hFF);
    $display("test host access done");
    final_report();
  end
endmodule : srcl_loader_test
bind srcl_loader srcl_loader_checker srcl_loader_checker_inst (.*);
